// [eph_odo_pkg.sv]
// Constants for the ephemeris packet builder and odometer packet decoder.
// Assumes a byte-wide packet stream; framing and checksum live elsewhere.
package eph_odo_pkg;
  // ----------------------------------------------------------------
  // Packet identifiers and lengths
  // ----------------------------------------------------------------
  localparam logic [7:0] EPH_PKT_ID      = 8'h3D; // 61
  localparam logic [7:0] RAW_OBS_PKT_ID  = 8'h3C; // 60
  localparam logic [7:0] ODO_PKT_ID      = 8'h43; // 67
  localparam logic [7:0] ODO_PKT_LEN     = 8'h0D; // 13
  localparam logic [7:0] EPH_HDR_LEN     = 8'h06;
  localparam logic [7:0] PRI_BODY_LEN    = 8'h84; // 132
  localparam logic [7:0] SEC_BODY_LEN    = 8'h5E; // 94
  // ----------------------------------------------------------------
  // Satellite system codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SYS_PRIMARY     = 8'h01;
  localparam logic [7:0] SYS_SECOND      = 8'h02;
  // ----------------------------------------------------------------
  // Ephemeris byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SYSTEM      = 8'h04;
  localparam logic [7:0] OFS_SAT_NUM     = 8'h05;
  localparam logic [7:0] OFS_REF_TIME    = 8'h06;
  localparam logic [7:0] OFS_CLK_ISSUE   = 8'h0A; // 10
  localparam logic [7:0] OFS_EPH_ISSUE   = 8'h0C; // 12
  localparam logic [7:0] OFS_CLK_BIAS    = 8'h0E; // 14
  localparam logic [7:0] OFS_CLK_DRIFT   = 8'h12; // 18
  localparam logic [7:0] OFS_CLK_RATE    = 8'h16; // 22
  localparam logic [7:0] OFS_WEEK        = 8'h7A; // 122
  localparam logic [7:0] OFS_XMIT_TIME   = 8'h7C; // 124
  localparam logic [7:0] OFS_RANGE_ACC   = 8'h80; // 128
  localparam logic [7:0] OFS_FLAGS       = 8'h82; // 130
  localparam logic [7:0] OFS_SEC_FBIAS   = 8'h0A; // 10
  localparam logic [7:0] OFS_SEC_POS     = 8'h0E; // 14
  localparam logic [7:0] OFS_SEC_VEL     = 8'h26; // 38
  localparam logic [7:0] OFS_SEC_ACC     = 8'h3E; // 62
  localparam logic [7:0] OFS_FRAME_TIME  = 8'h56; // 86
  localparam logic [7:0] OFS_AGE         = 8'h5A; // 90
  localparam logic [7:0] OFS_SLOT        = 8'h5B; // 91
  localparam logic [7:0] OFS_HEALTH      = 8'h5C; // 92
  localparam logic [7:0] OFS_RSVD        = 8'h5D; // 93
  // ----------------------------------------------------------------
  // Primary flags word fields
  // ----------------------------------------------------------------
  localparam int FLG_PCODE   = 0;
  localparam int FLG_L2_LO   = 1;
  localparam int FLG_SPOOF   = 3;
  localparam int FLG_HLTH_LO = 4;
  localparam int FLG_FIT     = 10;
  localparam int FLG_ACCBAD  = 11;
  localparam int FLG_BLK_LO  = 12;
  // ----------------------------------------------------------------
  // Odometer payload offsets and APB map
  // ----------------------------------------------------------------
  localparam logic [7:0] ODO_OFS_DELAY  = 8'h00;
  localparam logic [7:0] ODO_OFS_SPEED  = 8'h04;
  localparam logic [7:0] ODO_OFS_RSVD   = 8'h08;
  localparam logic [7:0] ODO_OFS_FLAGS  = 8'h0C; // 12
  localparam logic [11:0] REG_CTRL      = 12'h000;
  localparam logic [11:0] REG_STATUS    = 12'h004;
  localparam logic [11:0] REG_ODO_DELAY = 12'h008;
  localparam logic [11:0] REG_ODO_SPEED = 12'h00C;
  localparam logic [11:0] REG_ODO_FLAGS = 12'h010;
  // A primary packet is 138 bytes, so the image needs 35 words
  localparam logic [11:0] REG_EPH_BASE  = 12'h100; // 35 words of image
  localparam int          EPH_WORDS     = 35;
  localparam int          FIFO_DEPTH    = 4;
  localparam int          FIFO_WIDTH    = 9;    // byte plus last mark
endpackage : eph_odo_pkg

// [byte_fifo.sv]
// Small valid/ready FIFO in the outgoing byte path.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Honest flags straight from the count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // Pointers and count
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk)
  begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule : byte_fifo

// [eph_odo_codec.sv]
// Ephemeris packet builder and odometer packet decoder with APB registers.
// Assumes synchronous byte streams; framing/checksum done by the link.
`timescale 1ns/10ps

// Overview of operation
// RULE1 - Ephemeris id 61, timestamp, system, satellite number
// RULE2 - Ephemeris output follows raw observation enable
// RULE3 - Primary body 132 bytes, reference time first
// RULE4 - Clock issue at 10, ephemeris issue 12
// RULE5 - Clock bias, drift, rate at 14/18/22
// RULE6 - Week, transmit time, accuracy, flags at end
// RULE7 - Primary flags word bit layout
// RULE8 - Second body 94 bytes, biases first
// RULE9 - Position, velocity, acceleration doubles at 14/38/62
// RULE10 - Frame time, age, slot, health, reserved
// RULE11 - Odometer id 67, 13 bytes, write-only
// RULE12 - Odometer delay, speed, reserved, flags layout
// RULE13 - System byte picks body and length
// RULE14 - Wrong-length odometer packet is dropped
module eph_odo_codec
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Outgoing packet stream
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_data,
  output logic             tx_last,
  output logic [7:0]       tx_id,
  output logic [7:0]       tx_len,
  // Incoming packet stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_id,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  // Decoded odometer pulse
  output logic             odo_update
);
  import eph_odo_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_DONE = 2'b10
  } tx_state_t;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] img_q [EPH_WORDS];   // Ephemeris record image, little endian
  logic        obs_en_q;
  logic        send_q;
  tx_state_t   st_q;
  logic [7:0]  idx_q;
  logic [7:0]  len_q;
  logic [31:0] odo_delay_q;
  logic [31:0] odo_speed_q;
  logic [7:0]  odo_flags_q;
  logic [31:0] rx_sr_q [3];
  logic [7:0]  rx_cnt_q;
  logic        rx_bad_q;
  logic [7:0]  odo_cnt_q;
  logic [7:0]  drop_cnt_q;
  logic [7:0]  rx_flg_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire        acc     = psel && penable && !pready;
  wire        wr      = psel && penable && pready && pwrite;
  wire        in_img  = (paddr >= REG_EPH_BASE) &&
                        (paddr < REG_EPH_BASE + 12'(4*EPH_WORDS));
  wire [11:0] img_off = paddr - REG_EPH_BASE;
  wire [5:0]  img_ix  = img_off[7:2];
  wire        hit_ctl = (paddr == REG_CTRL);
  wire        mapped  = hit_ctl || (paddr == REG_STATUS) ||
                        (paddr == REG_ODO_DELAY) ||
                        (paddr == REG_ODO_SPEED) ||
                        (paddr == REG_ODO_FLAGS) || in_img;
  // Odometer values are write-only from the link; APB writes do nothing
  wire        ro_hit  = !hit_ctl && !in_img;

  // Read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (in_img)
      rd_mux = img_q[img_ix];
    else
      case (paddr)
        REG_CTRL:      rd_mux = {31'h0, obs_en_q};
        REG_STATUS:    rd_mux = {8'h00, drop_cnt_q, odo_cnt_q,
                                 6'h00, st_q};
        REG_ODO_DELAY: rd_mux = odo_delay_q;
        REG_ODO_SPEED: rd_mux = odo_speed_q;
        REG_ODO_FLAGS: rd_mux = {24'h0, odo_flags_q};
        default:       rd_mux = 32'h0000_0000;
      endcase
  end

  // One wait state: answer lands at the second access edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc;
      pslverr <= acc && (!mapped || (pwrite && ro_hit));
      prdata  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Control: bit0 observation enable, bit1 send request (self clearing)
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      obs_en_q <= 1'b0;
      send_q   <= 1'b0;
    end
    else
    begin
      if (wr && hit_ctl)
        obs_en_q <= pwdata[0];
      // Request set wins over its clear by the framer
      if (wr && hit_ctl && pwdata[1])
        send_q <= 1'b1;
      else if (st_q == ST_DONE)
        send_q <= 1'b0;
    end
  end

  // Image writes; software packs the fields at their byte offsets
  // (time 0, system 4, sat 5, body from 6; flags word at 130)
  always_ff @(posedge clk)
  begin
    if (wr && in_img)
      img_q[img_ix] <= pwdata;
  end

  // ----------------------------------------------------------------
  // Ephemeris framer
  // ----------------------------------------------------------------
  wire [7:0] sys_byte = img_q[1][7:0];                        // RULE1
  wire       sys_pri  = (sys_byte == SYS_PRIMARY);            // RULE13
  wire       sys_sec  = (sys_byte == SYS_SECOND);             // RULE13
  wire [7:0] pkt_len  = EPH_HDR_LEN +
                        (sys_pri ? PRI_BODY_LEN : SEC_BODY_LEN); // RULE13
  // Only started while raw observation output is on; a packet under way finishes
  wire       go       = send_q && obs_en_q && (sys_pri || sys_sec); // RULE2
  wire [31:0] cur_w   = img_q[idx_q[7:2]];
  wire [7:0]  cur_b   = cur_w[8*idx_q[1:0] +: 8];
  // Primary flags: bit 15 carries no field and is forced to zero
  wire        flag_hi = sys_pri && (idx_q == OFS_FLAGS + 8'h01);  // RULE7
  wire [7:0]  out_b   = flag_hi ? {1'b0, cur_b[6:0]} : cur_b;    // RULE7
  wire        last_b  = (idx_q == len_q - 8'h01);
  wire        f_rdy;
  wire        push    = (st_q == ST_SEND) && f_rdy;

  // Byte walk; the body is stored at its packet offsets, so offsets
  // 10/12/14/18/22/122..130 and 14/38/62/86..93 come out in place
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q  <= ST_IDLE;
      idx_q <= 8'h00;
      len_q <= 8'h00;
    end
    else
      case (st_q)
        ST_IDLE:
          if (go)
          begin
            st_q  <= ST_SEND;
            idx_q <= 8'h00;
            len_q <= pkt_len;                       // RULE3 RULE8
          end
        ST_SEND:
          if (push)
          begin
            idx_q <= idx_q + 8'h01;                 // RULE4 RULE5 RULE6
            if (last_b)
              st_q <= ST_DONE;                      // RULE9 RULE10
          end
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
  end

  wire [8:0] f_out;
  wire       f_val;
  byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (st_q == ST_SEND),
    .in_ready  (f_rdy),
    .in_data   ({last_b, out_b}),
    .out_valid (f_val),
    .out_ready (!tx_valid || tx_ready),
    .out_data  (f_out)
  );

  // Output stage registered so every port comes from a flop
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
      tx_last  <= 1'b0;
      tx_id    <= 8'h00;
      tx_len   <= 8'h00;
    end
    else
    begin
      if (!tx_valid || tx_ready)
      begin
        tx_valid <= f_val;
        // Empty FIFO reads unwritten storage; keep that off the pins
        tx_data  <= f_val ? f_out[7:0] : 8'h00;
        tx_last  <= f_val && f_out[8];
      end
      if (go && st_q == ST_IDLE)
      begin
        tx_id  <= EPH_PKT_ID;                       // RULE1
        tx_len <= pkt_len;                          // RULE13
      end
    end
  end

  // ----------------------------------------------------------------
  // Odometer decoder
  // ----------------------------------------------------------------
  wire odo_byte = rx_valid && (rx_id == ODO_PKT_ID);       // RULE11
  wire odo_good = odo_byte && rx_last && !rx_bad_q &&
                  (rx_cnt_q == ODO_PKT_LEN - 8'h01);       // RULE14

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_cnt_q    <= 8'h00;
      rx_bad_q    <= 1'b0;
      rx_sr_q[0]  <= 32'h0;
      rx_sr_q[1]  <= 32'h0;
      rx_sr_q[2]  <= 32'h0;
      rx_flg_q    <= 8'h00;
      odo_delay_q <= 32'h0;
      odo_speed_q <= 32'h0;
      odo_flags_q <= 8'h00;
      odo_cnt_q   <= 8'h00;
      drop_cnt_q  <= 8'h00;
      odo_update  <= 1'b0;
    end
    else
    begin
      odo_update <= odo_good;
      if (odo_byte)
      begin
        // Little-endian fields: delay 0, speed 4, reserved 8
        if (rx_cnt_q < ODO_OFS_FLAGS)                       // RULE12
          rx_sr_q[rx_cnt_q[3:2]][8*rx_cnt_q[1:0] +: 8] <= rx_data;
        if (rx_cnt_q >= ODO_PKT_LEN)
          rx_bad_q <= 1'b1;                                 // RULE14
        rx_cnt_q <= rx_last ? 8'h00 : rx_cnt_q + 8'h01;
        if (rx_last)
          rx_bad_q <= 1'b0;
        if (rx_last && !odo_good)
          drop_cnt_q <= drop_cnt_q + 8'h01;                 // RULE14
      end
      if (odo_good)
      begin
        odo_delay_q <= rx_sr_q[0];                          // RULE12
        odo_speed_q <= rx_sr_q[1];
        // Only bit 0 has meaning; upper bits kept zero
        odo_flags_q <= {7'h00, rx_data[0]};                 // RULE12
        odo_cnt_q   <= odo_cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_len_sel;
    @(posedge clk) disable iff (!reset_n)
    (st_q == ST_IDLE && go) |=> (tx_len == (sys_pri ? 8'h8A : 8'h64));
  endproperty
  a_len_sel: assert property (p_len_sel) // RULE13
    else $error("packet length does not match body");

  property p_id;
    @(posedge clk) disable iff (!reset_n)
    (st_q == ST_SEND) |-> (tx_id == 8'h3D);
  endproperty
  a_id: assert property (p_id) // RULE1
    else $error("ephemeris id wrong");

  property p_gate;
    @(posedge clk) disable iff (!reset_n)
    (st_q == ST_IDLE && !obs_en_q) |=> (st_q == ST_IDLE);
  endproperty
  a_gate: assert property (p_gate) // RULE2
    else $error("ephemeris sent without observation enable");

  sequence s_bad_end;
    odo_byte && rx_last && !odo_good;
  endsequence
  property p_drop;
    @(posedge clk) disable iff (!reset_n)
    s_bad_end |=> !odo_update && $stable(odo_speed_q);
  endproperty
  a_drop: assert property (p_drop) // RULE14
    else $error("bad odometer packet updated speed");

  property p_upd;
    @(posedge clk) disable iff (!reset_n)
    odo_good |=> odo_update ##0 (odo_flags_q[7:1] == 7'h00);
  endproperty
  a_upd: assert property (p_upd) // RULE12
    else $error("odometer update missing");

  property p_flag15;
    @(posedge clk) disable iff (!reset_n)
    (push && flag_hi) |-> !out_b[7];
  endproperty
  a_flag15: assert property (p_flag15) // RULE7
    else $error("unused flags bit sent");

  property p_len_done;
    @(posedge clk) disable iff (!reset_n)
    (push && last_b) |-> (idx_q == len_q - 8'h01) ##1 (st_q == ST_DONE);
  endproperty
  a_len_done: assert property (p_len_done) // RULE3
    else $error("packet did not end at its length");

  property p_wo;
    @(posedge clk) disable iff (!reset_n)
    (acc && pwrite && paddr == REG_ODO_SPEED) |=>
      pslverr ##0 $stable(odo_speed_q);
  endproperty
  a_wo: assert property (p_wo) // RULE11
    else $error("odometer register writable over bus");
endmodule : eph_odo_codec

// [eph_odo_host_model.sv]
// Host side of the packet link: drains ephemeris bytes, sends odometer packets.
// Assumes the codec's byte stream ports and a single clock.
`timescale 1ns/10ps
module eph_odo_host_model
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Ephemeris stream from the device
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  // Odometer stream to the device
  output logic            rx_valid,
  output logic [7:0]      rx_id,
  output logic [7:0]      rx_data,
  output logic            rx_last
);
  logic [7:0] got [0:255];
  int         n;
  int         last_at;
  int         cyc;

  // --------------------------------------------------------------
  // Drain side
  // --------------------------------------------------------------
  // Stall every third cycle so the device must hold a byte across each stall
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_ready <= 1'b0;
      cyc      <= 0;
    end
    else
    begin
      cyc      <= cyc + 1;
      tx_ready <= (cyc % 3) != 0;
      if (tx_valid && tx_ready)
      begin
        got[n] <= tx_data;
        n      <= n + 1;
        if (tx_last)
          last_at <= n;
      end
    end
  end

  // Forget what was collected before the next packet
  task automatic clear;
  begin
    n       = 0;
    last_at = -1;
  end
  endtask : clear

  // --------------------------------------------------------------
  // Send side
  // --------------------------------------------------------------
  // Bytes go out back to back; lines idle at inverted values between
  task automatic send(input logic [7:0] id, input int len,
                      input logic [103:0] pay);
  begin
    for (int i = 0; i < len; i++)
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_id    <= id;
      rx_data  <= pay[8*i+:8];
      rx_last  <= (i == len - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_id    <= ~id;
    rx_data  <= ~rx_data;
  end
  endtask : send

  initial
  begin
    rx_valid = 1'b0;
    rx_id    = 8'h00;
    rx_data  = 8'h00;
    rx_last  = 1'b0;
    clear();
  end
endmodule : eph_odo_host_model

// [ephemeris_odometer_packet_codec_tb_top.sv]
// Self-checking bench for the ephemeris/odometer codec over APB.
// Assumes the codec, its FIFO and the host model are compiled before it.
`timescale 1ns/10ps
module ephemeris_odometer_packet_codec_tb_top;
  import eph_odo_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic        tx_valid;
  logic        tx_ready;
  logic [7:0]  tx_data;
  logic        tx_last;
  logic [7:0]  tx_id;
  logic [7:0]  tx_len;
  logic        rx_valid;
  logic [7:0]  rx_id;
  logic [7:0]  rx_data;
  logic        rx_last;
  logic        odo_update;
  int          failures;
  int          checks_done;
  logic [31:0] rd;
  logic        err;
  logic [103:0] pay;

  eph_odo_codec uut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .tx_id(tx_id), .tx_len(tx_len),
    .rx_valid(rx_valid), .rx_id(rx_id), .rx_data(rx_data),
    .rx_last(rx_last), .odo_update(odo_update));

  eph_odo_host_model host (.clk(clk), .reset_n(reset_n),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_last(tx_last), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_data(rx_data), .rx_last(rx_last));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
  begin
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask : check

  task automatic test_done;
  begin
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask : test_done

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
  begin
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (k == 50)
    begin
      failures++;
      test_done();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  end
  endtask : apb

  function automatic logic [7:0] img(input int k, input logic [7:0] sys);
    img = (k == 4) ? sys : (k == 5) ? 8'h07 :
          (k == 32'(OFS_FLAGS) + 1) ? 8'hFF : (8'(k) ^ 8'hA5);
  endfunction : img

  // Load an image, start a send and compare every byte that comes out
  task automatic send_eph(input logic [7:0] sys, input int len);
    int         k;
    logic [7:0] e;
  begin
    for (int w = 0; w < EPH_WORDS; w++)
      apb(1'b1, REG_EPH_BASE + 12'(4 * w), {img(4*w+3, sys),
          img(4*w+2, sys), img(4*w+1, sys), img(4*w, sys)});
    host.clear();
    apb(1'b1, REG_CTRL, 32'h0000_0003);
    for (k = 0; k < 3000 && host.last_at < 0; k++)
      @(posedge clk);
    if (k == 3000)
    begin
      failures++;
      test_done();
    end
    repeat (2) @(posedge clk);
    check(32'(host.n), 32'(len));
    check(32'(host.last_at), 32'(len - 1));
    check({24'h0, tx_id}, {24'h0, EPH_PKT_ID});
    check({24'h0, tx_len}, 32'(len));
    // Bit 15 of the primary flags word carries no field and goes out as 0
    for (int i = 0; i < len; i++)
    begin
      e = (i == 32'(OFS_FLAGS) + 1) ? 8'h7F : img(i, sys);
      check({24'h0, host.got[i]}, {24'h0, e});
    end
  end
  endtask : send_eph

  // Odometer packet that must not be taken: no pulse follows
  task automatic odo_bad(input logic [7:0] id, input int len);
  begin
    host.send(id, len, pay);
    repeat (3)
    begin
      @(posedge clk);
      check({31'h0, odo_update}, 32'h0);
    end
  end
  endtask : odo_bad

  // --------------------------------------------------------------
  // Clock, reset and sequence
  // --------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    failures = 0;
    checks_done = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    check({31'h0, tx_valid}, 32'h0);
    // Unmapped read and read-only write are refused
    apb(1'b0, 12'h0F0, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    // Send without the observation enable produces nothing
    host.clear();
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    repeat (40) @(posedge clk);
    check(32'(host.n), 32'h0);
    send_eph(SYS_PRIMARY, 138);
    send_eph(SYS_SECOND, 100);
    // Good odometer packet: flags bit0 set, reserved float zero
    pay = {8'h01, 32'h0, 32'h4120_0000, 32'h3C23_D70A};
    host.send(ODO_PKT_ID, 13, pay);
    @(posedge clk);
    check({31'h0, odo_update}, 32'h1);
    apb(1'b0, REG_ODO_DELAY, 32'h0);
    check(rd, 32'h3C23_D70A);
    apb(1'b0, REG_ODO_SPEED, 32'h0);
    check(rd, 32'h4120_0000);
    apb(1'b0, REG_ODO_FLAGS, 32'h0);
    check(rd, 32'h0000_0001);
    // Odometer values come only from the link; a bus write is refused
    apb(1'b1, REG_ODO_SPEED, 32'h1234_5678);
    check({31'h0, err}, 32'h1);
    // Short packet and foreign id leave the stored values alone
    pay = {8'h00, 96'h0};
    odo_bad(ODO_PKT_ID, 12);
    odo_bad(8'h44, 13);
    apb(1'b0, REG_ODO_SPEED, 32'h0);
    check(rd, 32'h4120_0000);
    apb(1'b0, REG_STATUS, 32'h0);
    check({16'h0, rd[23:8]}, 32'h0000_0101);
    test_done();
  end
endmodule : ephemeris_odometer_packet_codec_tb_top
